// ==== cfer_clk_gate.sv ====
// Bank of glitch-free clock gates, one per source clock.
// Assumes enables are quasi-static and come from the register clock domain.
`timescale 1ns/100ps

module cfer_clk_gate #(
  parameter int N = 32
) (
  input wire logic rst_n_i,
  cfer_gate_if.gate gif
);

  // ----------------------------------------------------------------------
  // Gate cells
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_gate
      logic en_meta;
      logic en_low;

      // Enable crosses into the source domain before it reaches the gate
      always_ff @(posedge gif.src_clk[g]) begin
        if (!rst_n_i) begin
          en_meta <= 1'b0;
        end else begin
          en_meta <= gif.enable[g];
        end
      end

      // update while low
      // A falling edge update keeps the enable still through each high phase
      always_ff @(negedge gif.src_clk[g]) begin
        if (!rst_n_i) begin
          en_low <= 1'b0;
        end else begin
          en_low <= en_meta;
        end
      end

      assign gif.gated_clk[g] = gif.src_clk[g] & en_low;
    end
  endgenerate

endmodule

// ==== cfer_defs.svh ====
// Register offsets, field positions and reset values of the clock fanout enables.
// Assumes inclusion by bare name from the design files.
`ifndef CFER_DEFS_SVH
`define CFER_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CFER_OFS_LOCK_CNFG 8'h00
`define CFER_OFS_LOCK_THR 8'h04
`define CFER_OFS_ANA_EN 8'h08
`define CFER_OFS_BANK_EN 8'h0c

// ----------------------------------------------------------------------
// Lock configuration and thresholds
// ----------------------------------------------------------------------
`define CFER_PREC_EN_BIT 9
`define CFER_PREC_EN_RST 1'h1
`define CFER_THR_HI_MSB 7
`define CFER_THR_HI_LSB 4
`define CFER_THR_LO_MSB 3
`define CFER_THR_LO_LSB 0
`define CFER_THR_HI_RST 4'h6
`define CFER_THR_LO_RST 4'ha

// ----------------------------------------------------------------------
// Crystal clock fanout enables
// ----------------------------------------------------------------------
`define CFER_ANA_OMUX 6
`define CFER_ANA_X1_DIV_LOGIC 5
`define CFER_ANA_X0_DIV_LOGIC 4
`define CFER_ANA_X1_LOGIC 3
`define CFER_ANA_X0_LOGIC 2
`define CFER_ANA_X1_PLL 1
`define CFER_ANA_X0_PLL 0
`define CFER_ANA_WIDTH 7
`define CFER_ANA_RST 7'h3f

// ----------------------------------------------------------------------
// Output bank mux enables
// ----------------------------------------------------------------------
`define CFER_BANK_WIDTH 25
`define CFER_BANK_RST 25'h1ffffff
`define CFER_BANK_HP2_LSB 21
`define CFER_BANK_HP1_LSB 14
`define CFER_BANK_HP0_LSB 10
`define CFER_BANK_INT1_LSB 7
`define CFER_BANK_INT0_LSB 5
`define CFER_BANK_LP1_LSB 2
`define CFER_BANK_LP0_LSB 0

`endif

// ==== cfer_gate_if.sv ====
// Bundle between the register block and its clock gate bank.
// Assumes every source clock is free running while its gate is changed.
`timescale 1ns/100ps

interface cfer_gate_if #(
  parameter int N = 32
);
  logic [N-1:0] src_clk;
  logic [N-1:0] enable;
  logic [N-1:0] gated_clk;

  modport ctrl (output src_clk, output enable, input gated_clk);
  modport gate (input src_clk, input enable, output gated_clk);
endinterface

// ==== cfer_pkg.sv ====
// Types shared by the clock fanout enable block.
// Assumes nothing of its surroundings.
package cfer_pkg;

  // ----------------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CFER_SEL_NONE = 3'h0,
    CFER_SEL_LOCK_CNFG = 3'h1,
    CFER_SEL_LOCK_THR = 3'h3,
    CFER_SEL_ANA_EN = 3'h2,
    CFER_SEL_BANK_EN = 3'h6
  } cfer_sel_t;

endpackage

// ==== cfer_top.sv ====
// Control registers of the clock generator: lock thresholds and clock fanout gates.
// Assumes a plain register port on clk_sys_i and free running source clocks.
`timescale 1ns/100ps
`include "cfer_defs.svh"

module cfer_top
  import cfer_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [3:0] lock_high_threshold_code_o,
  output logic [3:0] lock_low_threshold_code_o,
  output logic precision_lock_enable_o,
  input wire logic crystal0_clk_i,
  input wire logic crystal1_clk_i,
  input wire logic crystal0_div_clk_i,
  input wire logic crystal1_div_clk_i,
  input wire logic pll_ref_sel_clk_i,
  input wire logic [2:0] hp_div_clk_i,
  input wire logic [1:0] int_div_clk_i,
  input wire logic [1:0] lp_div_clk_i,
  output logic pll_ref_to_omux_clk_o,
  output logic crystal1_div_logic_clk_o,
  output logic crystal0_div_logic_clk_o,
  output logic crystal1_logic_clk_o,
  output logic crystal0_logic_clk_o,
  output logic crystal1_pll_clk_o,
  output logic crystal0_pll_clk_o,
  output logic [`CFER_BANK_WIDTH-1:0] bank_mux_clk_o
);

  localparam int NG = `CFER_ANA_WIDTH + `CFER_BANK_WIDTH;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic cfer_sel_t cfer_decode(input logic [AW-1:0] addr);
    cfer_sel_t sel;
    sel = CFER_SEL_NONE;
    case (addr[7:0])
      `CFER_OFS_LOCK_CNFG: sel = CFER_SEL_LOCK_CNFG;
      `CFER_OFS_LOCK_THR: sel = CFER_SEL_LOCK_THR;
      `CFER_OFS_ANA_EN: sel = CFER_SEL_ANA_EN;
      `CFER_OFS_BANK_EN: sel = CFER_SEL_BANK_EN;
      default: sel = CFER_SEL_NONE;
    endcase
    // Upper address bits must be zero, so no register is aliased higher up
    if (AW > 8 && (addr >> 8) != '0) begin
      sel = CFER_SEL_NONE;
    end
    return sel;
  endfunction

  cfer_sel_t sel;
  assign sel = cfer_decode(reg_addr_i);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic prec_en;
  logic [3:0] thr_hi;
  logic [3:0] thr_lo;
  logic [`CFER_ANA_WIDTH-1:0] ana_en;
  logic [`CFER_BANK_WIDTH-1:0] bank_en;
  logic next_prec_en;
  logic [3:0] next_thr_hi;
  logic [3:0] next_thr_lo;
  logic [`CFER_ANA_WIDTH-1:0] next_ana_en;
  logic [`CFER_BANK_WIDTH-1:0] next_bank_en;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  // A write to an unmapped address falls to the default branch and changes nothing
  always_comb begin
    next_prec_en = prec_en;
    next_thr_hi = thr_hi;
    next_thr_lo = thr_lo;
    next_ana_en = ana_en;
    next_bank_en = bank_en;
    if (reg_wr_i) begin
      case (sel)
        CFER_SEL_LOCK_CNFG: begin
          next_prec_en = reg_wdata_i[`CFER_PREC_EN_BIT];
        end
        CFER_SEL_LOCK_THR: begin
          next_thr_hi = reg_wdata_i[`CFER_THR_HI_MSB:`CFER_THR_HI_LSB];
          next_thr_lo = reg_wdata_i[`CFER_THR_LO_MSB:`CFER_THR_LO_LSB];
        end
        CFER_SEL_ANA_EN: begin
          next_ana_en = reg_wdata_i[`CFER_ANA_WIDTH-1:0];
        end
        CFER_SEL_BANK_EN: begin
          next_bank_en = reg_wdata_i[`CFER_BANK_WIDTH-1:0];
        end
        default: begin
          next_prec_en = prec_en;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Data is presented only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (sel)
        CFER_SEL_LOCK_CNFG: begin
          next_rdata[`CFER_PREC_EN_BIT] = prec_en;
        end
        CFER_SEL_LOCK_THR: begin
          next_rdata[`CFER_THR_HI_MSB:`CFER_THR_HI_LSB] = thr_hi;
          next_rdata[`CFER_THR_LO_MSB:`CFER_THR_LO_LSB] = thr_lo;
        end
        CFER_SEL_ANA_EN: begin
          next_rdata[`CFER_ANA_WIDTH-1:0] = ana_en;
        end
        CFER_SEL_BANK_EN: begin
          next_rdata[`CFER_BANK_WIDTH-1:0] = bank_en;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  // Reset is synchronous: a pulse that spans no rising clk_sys_i edge is lost
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prec_en <= `CFER_PREC_EN_RST;
      thr_hi <= `CFER_THR_HI_RST;
      thr_lo <= `CFER_THR_LO_RST;
      ana_en <= `CFER_ANA_RST;
      bank_en <= `CFER_BANK_RST;
    end else begin
      prec_en <= next_prec_en;
      thr_hi <= next_thr_hi;
      thr_lo <= next_thr_lo;
      ana_en <= next_ana_en;
      bank_en <= next_bank_en;
    end
  end

  // ----------------------------------------------------------------------
  // Lock detector settings
  // ----------------------------------------------------------------------
  logic [3:0] next_thr_hi_o;
  logic [3:0] next_thr_lo_o;

  // codes used while enabled
  // Codes hold their last values while the detector is off, so a later
  // enable never sees a half-written pair
  always_comb begin
    next_thr_hi_o = lock_high_threshold_code_o;
    next_thr_lo_o = lock_low_threshold_code_o;
    if (next_prec_en) begin
      next_thr_hi_o = next_thr_hi;
      next_thr_lo_o = next_thr_lo;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lock_high_threshold_code_o <= `CFER_THR_HI_RST;
      lock_low_threshold_code_o <= `CFER_THR_LO_RST;
      precision_lock_enable_o <= `CFER_PREC_EN_RST;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      lock_high_threshold_code_o <= next_thr_hi_o;
      lock_low_threshold_code_o <= next_thr_lo_o;
      precision_lock_enable_o <= next_prec_en;
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Clock gate bank
  // ----------------------------------------------------------------------
  cfer_gate_if #(.N(NG)) gif ();

  // ----------------------------------------------------------------------
  // Crystal clock sources
  // ----------------------------------------------------------------------
  // Each crystal feeds two gates, so its logic and PLL paths stop apart
  logic [`CFER_ANA_WIDTH-1:0] ana_src;

  always_comb begin
    ana_src = '0;
    ana_src[`CFER_ANA_OMUX] = pll_ref_sel_clk_i;
    ana_src[`CFER_ANA_X1_DIV_LOGIC] = crystal1_div_clk_i;
    ana_src[`CFER_ANA_X0_DIV_LOGIC] = crystal0_div_clk_i;
    ana_src[`CFER_ANA_X1_LOGIC] = crystal1_clk_i;
    ana_src[`CFER_ANA_X0_LOGIC] = crystal0_clk_i;
    ana_src[`CFER_ANA_X1_PLL] = crystal1_clk_i;
    ana_src[`CFER_ANA_X0_PLL] = crystal0_clk_i;
  end

  // ----------------------------------------------------------------------
  // Bank mux sources
  // ----------------------------------------------------------------------
  // One divider fans out to several banks; each bank keeps a gate of its own
  logic [`CFER_BANK_WIDTH-1:0] bank_src;

  always_comb begin
    bank_src = '0;
    bank_src[`CFER_BANK_WIDTH-1:`CFER_BANK_HP2_LSB] = {4{hp_div_clk_i[2]}};
    bank_src[`CFER_BANK_HP2_LSB-1:`CFER_BANK_HP1_LSB] = {7{hp_div_clk_i[1]}};
    bank_src[`CFER_BANK_HP1_LSB-1:`CFER_BANK_HP0_LSB] = {4{hp_div_clk_i[0]}};
    bank_src[`CFER_BANK_HP0_LSB-1:`CFER_BANK_INT1_LSB] = {3{int_div_clk_i[1]}};
    bank_src[`CFER_BANK_INT1_LSB-1:`CFER_BANK_INT0_LSB] = {2{int_div_clk_i[0]}};
    bank_src[`CFER_BANK_INT0_LSB-1:`CFER_BANK_LP1_LSB] = {3{lp_div_clk_i[1]}};
    bank_src[`CFER_BANK_LP1_LSB-1:`CFER_BANK_LP0_LSB] = {2{lp_div_clk_i[0]}};
  end

  assign gif.src_clk = {bank_src, ana_src};
  assign gif.enable = {bank_en, ana_en};

  // Gate cells reset closed; each enabled one opens once its own source clock runs again
  // glitch-free gating
  cfer_clk_gate #(.N(NG)) u_gate (
    .rst_n_i(rst_n_i),
    .gif(gif)
  );

  // ----------------------------------------------------------------------
  // Gated clock outputs
  // ----------------------------------------------------------------------
  // Gated clocks cannot be retimed; they come straight from the gate cells
  assign pll_ref_to_omux_clk_o = gif.gated_clk[`CFER_ANA_OMUX];
  assign crystal1_div_logic_clk_o = gif.gated_clk[`CFER_ANA_X1_DIV_LOGIC];
  assign crystal0_div_logic_clk_o = gif.gated_clk[`CFER_ANA_X0_DIV_LOGIC];
  assign crystal1_logic_clk_o = gif.gated_clk[`CFER_ANA_X1_LOGIC];
  assign crystal0_logic_clk_o = gif.gated_clk[`CFER_ANA_X0_LOGIC];
  assign crystal1_pll_clk_o = gif.gated_clk[`CFER_ANA_X1_PLL];
  assign crystal0_pll_clk_o = gif.gated_clk[`CFER_ANA_X0_PLL];
  assign bank_mux_clk_o = gif.gated_clk[NG-1:`CFER_ANA_WIDTH];

endmodule

// ==== cfer_top_properties.sv ====
// Concurrent checks on the ports of the clock fanout enable registers.
// Assumes a plain register port on clk_sys_i and free running source clocks.
`timescale 1ns/100ps
`include "cfer_defs.svh"

module cfer_top_properties #(
  parameter int AW = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [3:0] lock_high_threshold_code_o,
  input wire logic [3:0] lock_low_threshold_code_o,
  input wire logic precision_lock_enable_o,
  input wire logic crystal0_clk_i,
  input wire logic [1:0] lp_div_clk_i,
  input wire logic crystal0_logic_clk_o,
  input wire logic pll_ref_to_omux_clk_o,
  input wire logic [`CFER_BANK_WIDTH-1:0] bank_mux_clk_o
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] A_CNFG = AW'(`CFER_OFS_LOCK_CNFG);
  localparam logic [AW-1:0] A_THR = AW'(`CFER_OFS_LOCK_THR);
  localparam logic [AW-1:0] A_ANA = AW'(`CFER_OFS_ANA_EN);
  localparam logic [AW-1:0] A_BANK = AW'(`CFER_OFS_BANK_EN);
  logic [31:0] wdata_q;

  always_ff @(posedge clk_sys_i) begin
    wdata_q <= reg_wdata_i;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_reset_values:
    assert property ($rose(rst_n_i) |-> lock_high_threshold_code_o == 4'h6
      && lock_low_threshold_code_o == 4'ha && precision_lock_enable_o)
    else $error("Threshold outputs wrong after reset");
  a_thr_follow:
    assert property (reg_wr_i && reg_addr_i == A_THR && precision_lock_enable_o |=>
      {lock_high_threshold_code_o, lock_low_threshold_code_o} == wdata_q[7:0])
    else $error("Threshold outputs did not take the write");
  a_thr_frozen:
    assert property (!precision_lock_enable_o && !(reg_wr_i && reg_addr_i == A_CNFG) |=>
      $stable(lock_high_threshold_code_o) && $stable(lock_low_threshold_code_o))
    else $error("Thresholds moved while detector disabled");
  a_prec_copy:
    assert property (reg_wr_i && reg_addr_i == A_CNFG |=> precision_lock_enable_o == wdata_q[9])
    else $error("Detector enable not taken from bit 9");
  a_ana_reserved:
    assert property (reg_rd_i && reg_addr_i == A_ANA |=> reg_rdata_o[31:7] == 25'h0)
    else $error("Reserved crystal enable bits read nonzero");
  a_unmapped_zero:
    assert property (reg_rd_i && (reg_addr_i >> 8) != 0 |=> reg_rdata_o == 32'h0)
    else $error("Unmapped read returned data");
  a_gate_in_src:
    assert property (!(crystal0_logic_clk_o && !crystal0_clk_i)
      && !(bank_mux_clk_o[0] && !lp_div_clk_i[0]))
    else $error("Gated clock high while its source is low");
  a_ana_off:
    assert property (reg_wr_i && reg_addr_i == A_ANA && reg_wdata_i[6:0] == 7'h0 |->
      ##6 (!crystal0_logic_clk_o && !pll_ref_to_omux_clk_o) [*8])
    else $error("Crystal clock passed after its gate was cleared");
  a_bank_off:
    assert property (reg_wr_i && reg_addr_i == A_BANK && reg_wdata_i[24:0] == 25'h0 |->
      ##6 (bank_mux_clk_o == 25'h0) [*8])
    else $error("Bank mux clock passed after its gate was cleared");
endmodule

bind cfer_top cfer_top_properties #(.AW(AW)) i_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .lock_high_threshold_code_o(lock_high_threshold_code_o),
  .lock_low_threshold_code_o(lock_low_threshold_code_o),
  .precision_lock_enable_o(precision_lock_enable_o), .crystal0_clk_i(crystal0_clk_i),
  .lp_div_clk_i(lp_div_clk_i), .crystal0_logic_clk_o(crystal0_logic_clk_o),
  .pll_ref_to_omux_clk_o(pll_ref_to_omux_clk_o), .bank_mux_clk_o(bank_mux_clk_o)
);

// ==== cfer_top_tb.sv ====
// Self-checking bench of the clock fanout enable registers.
// Assumes a 12-bit address, so bit 8 set marks an unmapped place.
`timescale 1ns/100ps

module cfer_top_tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q;} cfer_row_t;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic src_clk = 1'b0;
  // One bit per source clock, so each source can run alone and expose its gates
  logic [11:0] src_run = 12'hfff;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0] thr_hi;
  logic [3:0] thr_lo;
  logic prec_en;
  wire [6:0] ana_clk;
  wire [24:0] bank_clk;
  int error_cnt = 0;
  int n_compared = 0;
  cfer_row_t rows[9] = '{'{12'h004, 32'h0000003c, 32'h0000003c},
    '{12'h004, 32'hffffffff, 32'h000000ff}, '{12'h008, 32'hffffffff, 32'h0000007f},
    '{12'h008, 32'h00000000, 32'h00000000}, '{12'h00c, 32'hffffffff, 32'h01ffffff},
    '{12'h00c, 32'h00000000, 32'h00000000}, '{12'h000, 32'hfffffdff, 32'h00000000},
    '{12'h000, 32'hffffffff, 32'h00000200}, '{12'h100, 32'hffffffff, 32'h00000000}};
  // Gated outputs expected when only source k runs and every gate is open
  logic [31:0] src_exp[12] = '{32'h0a000000, 32'h14000000, 32'h20000000, 32'h40000000,
    32'h80000000, 32'h00003c00, 32'h001fc000, 32'h01e00000, 32'h00000060, 32'h00000380,
    32'h00000003, 32'h0000001c};

  always #5 clk_sys_i = ~clk_sys_i;
  // Period unrelated to clk_sys_i so gate sampling walks across the phase
  always #7 src_clk = ~src_clk;

  cfer_top #(.AW(12)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .lock_high_threshold_code_o(thr_hi), .lock_low_threshold_code_o(thr_lo),
    .precision_lock_enable_o(prec_en), .crystal0_clk_i(src_clk & src_run[0]),
    .crystal1_clk_i(src_clk & src_run[1]), .crystal0_div_clk_i(src_clk & src_run[2]),
    .crystal1_div_clk_i(src_clk & src_run[3]), .pll_ref_sel_clk_i(src_clk & src_run[4]),
    .hp_div_clk_i({3{src_clk}} & src_run[7:5]), .int_div_clk_i({2{src_clk}} & src_run[9:8]),
    .lp_div_clk_i({2{src_clk}} & src_run[11:10]),
    .pll_ref_to_omux_clk_o(ana_clk[6]), .crystal1_div_logic_clk_o(ana_clk[5]),
    .crystal0_div_logic_clk_o(ana_clk[4]), .crystal1_logic_clk_o(ana_clk[3]),
    .crystal0_logic_clk_o(ana_clk[2]), .crystal1_pll_clk_o(ana_clk[1]),
    .crystal0_pll_clk_o(ana_clk[0]), .bank_mux_clk_o(bank_clk)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    // Strobes last exactly one cycle
    @(posedge clk_sys_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0);
    #1;
    check(rdata, exp);
  endtask

  // Gate latency is a couple of source cycles, so wait before collecting
  task automatic gates(input logic [31:0] exp);
    logic [31:0] seen;
    seen = 32'h0;
    repeat (6) @(posedge clk_sys_i);
    repeat (30) begin
      @(negedge clk_sys_i);
      seen = seen | {ana_clk, bank_clk};
    end
    check(seen, exp);
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  endtask

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk(12'h000, 32'h00000200);
    rd_chk(12'h004, 32'h0000006a);
    rd_chk(12'h008, 32'h0000003f);
    rd_chk(12'h00c, 32'h01ffffff);
    check({23'h0, thr_hi, thr_lo, prec_en}, 32'h000000d5);
    gates({7'h3f, 25'h1ffffff});
    $display("Reset values test done");
    foreach (rows[i]) begin
      bus(1'b1, 1'b0, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].q);
    end
    gates(32'h0);
    $display("Register table test done");
    bus(1'b1, 1'b0, 12'h008, 32'h0000002a);
    bus(1'b1, 1'b0, 12'h00c, 32'h01555555);
    gates({7'h2a, 25'h1555555});
    bus(1'b1, 1'b0, 12'h008, 32'hffffffd5);
    bus(1'b1, 1'b0, 12'h00c, 32'hfeaaaaaa);
    gates({7'h55, 25'h0aaaaaa});
    $display("Gate mapping test done");
    bus(1'b1, 1'b0, 12'h008, 32'h0000007f);
    bus(1'b1, 1'b0, 12'h00c, 32'h01ffffff);
    for (int k = 0; k < 12; k++) begin
      @(posedge clk_sys_i);
      src_run <= 12'h001 << k;
      gates(src_exp[k]);
    end
    @(posedge clk_sys_i);
    src_run <= 12'hfff;
    $display("Source mapping test done");
    bus(1'b1, 1'b0, 12'h000, 32'h0);
    bus(1'b1, 1'b0, 12'h004, 32'h00000051);
    rd_chk(12'h004, 32'h00000051);
    check({24'h0, thr_hi, thr_lo}, 32'h000000ff);
    bus(1'b1, 1'b0, 12'h000, 32'h00000200);
    bus(1'b0, 1'b0, 12'h000, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({24'h0, thr_hi, thr_lo}, 32'h00000051);
    $display("Detector enable test done");
    do_reset();
    rd_chk(12'h004, 32'h0000006a);
    rd_chk(12'h008, 32'h0000003f);
    $display("Second reset test done");
    end_sim();
  end

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
